// ===== rtl/ct16_timer.sv
// Purpose: Two 8-bit counters chained into a 16-bit interval timer / event counter
// Assumes: APB slave, zero wait states, single clock pclk
// Notes: Counters are held at zero unless both cascade and enable are set
// Summary of operation
// (R1) Mode bit 2 set to 1 selects cascaded 16-bit counting.
// (R2) Low counter clock comes from clock-select field bits 0 to 3.
// (R3) High counter increments only on low counter overflow.
// (R4) Count-enable bit 0 starts or stops the combined counter.
// (R5) Compare upper byte in high compare, lower byte in low compare.
// (R6) On full match both counters clear, high interrupt raised, counting continues.
// (R7) Interrupt repeats every N+1 count clocks, N from 0000H to FFFFH.
// (R8) Low match still raises low interrupt and toggles output flip-flop.
// (R9) Codes 0,1 external; 6..14 divide 2..2^9, 15 2^11; doubled if osc bit 0.
// (R10) Output level preset by level reset and level set bits 2 and 3.
// (R11) Software picks rising or falling external edge as counting edge.
// (R12) One read returns both counter halves coherently.
`timescale 1ns/1ps
`include "ct16_map.svh"
module ct16_timer
  import ct16_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CT16_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  output logic first_timer_output,
  output logic irq
);
  logic [7:0] timer_mode_control_a_reg;
  logic [3:0] timer_clock_select_a_reg;
  ct16_byte_t low_compare_reg;
  ct16_byte_t high_compare_reg;
  logic oscillation_mode_reg;
  logic [1:0] irq_en_reg;
  logic [1:0] irq_stat_reg;
  ct16_byte_t low_counter_reg;
  ct16_byte_t high_counter_reg;
  logic out_ff_reg;
  logic [31:0] prdata_reg;

  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [1:0] irq_clr;
  ct16_src_e src;
  logic [3:0] exp_sel;
  logic int_tick;
  logic ext_tick;
  logic tick;
  logic run;
  logic low_hit;
  logic full_hit;
  logic low_evt;
  logic high_evt;
  logic outctl_wr;

  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign outctl_wr = wr_en && paddr == `CT16_OFF_OUTCTL;

  always_comb begin
    unique case (paddr)
      `CT16_OFF_MODE, `CT16_OFF_CLKSEL, `CT16_OFF_OUTCTL, `CT16_OFF_LOW_CMP,
      `CT16_OFF_HIGH_CMP, `CT16_OFF_COUNT, `CT16_OFF_OSC, `CT16_OFF_IRQ_STAT,
      `CT16_OFF_IRQ_CLR, `CT16_OFF_IRQ_EN: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Zero wait states; error only for unmapped words
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_reg;

  // (R1) mode and enable bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_control_a_reg <= `CT16_RST_MODE;
    end else if (wr_en && paddr == `CT16_OFF_MODE) begin
      timer_mode_control_a_reg <= pwdata[7:0];
    end
  end

  // (R2) clock-select field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_clock_select_a_reg <= `CT16_RST_CLKSEL;
    end else if (wr_en && paddr == `CT16_OFF_CLKSEL) begin
      timer_clock_select_a_reg <= pwdata[3:0];
    end
  end

  // (R5) compare bytes kept apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_compare_reg <= `CT16_RST_CMP;
      high_compare_reg <= `CT16_RST_CMP;
    end else if (wr_en && paddr == `CT16_OFF_LOW_CMP) begin
      low_compare_reg <= pwdata[7:0];
    end else if (wr_en && paddr == `CT16_OFF_HIGH_CMP) begin
      high_compare_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillation_mode_reg <= `CT16_RST_OSC;
      irq_en_reg <= `CT16_RST_IRQ;
    end else if (wr_en && paddr == `CT16_OFF_OSC) begin
      oscillation_mode_reg <= pwdata[`CT16_BIT_OSC];
    end else if (wr_en && paddr == `CT16_OFF_IRQ_EN) begin
      irq_en_reg <= pwdata[1:0];
    end
  end

  // (R9) code decode to source and divider exponent
  always_comb begin
    src = CT16_SRC_NONE;
    exp_sel = 4'h0;
    if (timer_clock_select_a_reg <= 4'h1) begin
      src = CT16_SRC_EXT;
    end else if (timer_clock_select_a_reg >= `CT16_CODE_INT_FIRST &&
                 timer_clock_select_a_reg <= `CT16_CODE_INT_LAST) begin
      src = CT16_SRC_INT;
      exp_sel = timer_clock_select_a_reg - `CT16_CODE_EXP_BIAS;
    end else if (timer_clock_select_a_reg == `CT16_CODE_SLOWEST) begin
      src = CT16_SRC_INT;
      exp_sel = `CT16_EXP_SLOWEST;
    end
    // Slow oscillation mode doubles every divider
    if (src == CT16_SRC_INT && !oscillation_mode_reg) begin
      exp_sel = exp_sel + 4'h1;
    end
  end

  ct16_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .exp_sel(exp_sel),
    .tick(int_tick)
  );

  // (R11) code bit 0 picks the rising edge
  ct16_edge_det u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(external_count_input),
    .rise_sel(timer_clock_select_a_reg[0]),
    .edge_tick(ext_tick)
  );

  // (R4) run gate
  assign run = timer_mode_control_a_reg[`CT16_BIT_CASCADE] & timer_mode_control_a_reg[`CT16_BIT_EN];
  assign tick = run & ((src == CT16_SRC_INT & int_tick) | (src == CT16_SRC_EXT & ext_tick));
  assign low_hit = low_counter_reg == low_compare_reg;
  assign full_hit = low_hit & (high_counter_reg == high_compare_reg);
  assign low_evt = tick & low_hit;
  assign high_evt = tick & full_hit;

  // (R3) cascaded count, high on low overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_counter_reg <= 8'h00;
      high_counter_reg <= 8'h00;
    end else if (!run) begin
      low_counter_reg <= 8'h00;
      high_counter_reg <= 8'h00;
    end else if (tick) begin
      // (R6) full match clears both
      if (full_hit) begin
        low_counter_reg <= 8'h00;
        high_counter_reg <= 8'h00;
      end else begin
        low_counter_reg <= low_counter_reg + 8'h01;
        if (low_counter_reg == 8'hff) begin
          high_counter_reg <= high_counter_reg + 8'h01;
        end
      end
    end
  end

  // (R8) low match toggles output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff_reg <= 1'b0;
    end else if (outctl_wr && pwdata[`CT16_BIT_LVL_SET] && !pwdata[`CT16_BIT_LVL_RESET]) begin
      // (R10) level preset
      out_ff_reg <= 1'b1;
    end else if (outctl_wr && pwdata[`CT16_BIT_LVL_RESET] && !pwdata[`CT16_BIT_LVL_SET]) begin
      out_ff_reg <= 1'b0;
    end else if (low_evt) begin
      out_ff_reg <= ~out_ff_reg;
    end
  end
  assign first_timer_output = out_ff_reg;

  assign irq_clr = (wr_en && paddr == `CT16_OFF_IRQ_CLR) ? pwdata[1:0] : 2'h0;

  // (R7) sticky events, set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= `CT16_RST_IRQ;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | {high_evt, low_evt};
    end
  end
  assign irq = |(irq_stat_reg & irq_en_reg);

  // (R12) snapshot at setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        `CT16_OFF_MODE: prdata_reg <= {24'h0, timer_mode_control_a_reg};
        `CT16_OFF_CLKSEL: prdata_reg <= {28'h0, timer_clock_select_a_reg};
        `CT16_OFF_LOW_CMP: prdata_reg <= {24'h0, low_compare_reg};
        `CT16_OFF_HIGH_CMP: prdata_reg <= {24'h0, high_compare_reg};
        `CT16_OFF_COUNT: prdata_reg <= {16'h0, high_counter_reg, low_counter_reg};
        `CT16_OFF_OSC: prdata_reg <= {31'h0, oscillation_mode_reg};
        `CT16_OFF_IRQ_STAT: prdata_reg <= {30'h0, irq_stat_reg};
        `CT16_OFF_IRQ_EN: prdata_reg <= {30'h0, irq_en_reg};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  property p_mode_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `CT16_OFF_MODE) |=>
      timer_mode_control_a_reg[`CT16_BIT_CASCADE] == $past(pwdata[`CT16_BIT_CASCADE]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("cascade bit not stored"); // (R1)

  property p_bad_code;
    @(posedge pclk) disable iff (!presetn)
    (timer_clock_select_a_reg inside {4'h2, 4'h3, 4'h4, 4'h5}) |-> !tick;
  endproperty
  a_bad_code: assert property (p_bad_code) else $error("prohibited code produced a tick"); // (R2)

  property p_carry;
    @(posedge pclk) disable iff (!presetn)
    (tick && !full_hit && low_counter_reg == 8'hff) |=>
      low_counter_reg == 8'h00 && high_counter_reg == $past(high_counter_reg) + 8'h01;
  endproperty
  a_carry: assert property (p_carry) else $error("high counter missed low overflow"); // (R3)

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    !run |=> low_counter_reg == 8'h00 && high_counter_reg == 8'h00;
  endproperty
  a_stop: assert property (p_stop) else $error("counter moved while stopped"); // (R4)

  property p_hcmp;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `CT16_OFF_HIGH_CMP) |=> high_compare_reg == $past(pwdata[7:0]);
  endproperty
  a_hcmp: assert property (p_hcmp) else $error("high compare not loaded"); // (R5)

  property p_full;
    @(posedge pclk) disable iff (!presetn)
    high_evt |=> low_counter_reg == 8'h00 && high_counter_reg == 8'h00 && irq_stat_reg[`CT16_IRQ_HIGH];
  endproperty
  a_full: assert property (p_full) else $error("full match did not clear and flag"); // (R6)

  property p_step;
    @(posedge pclk) disable iff (!presetn)
    (tick && !full_hit) |=> low_counter_reg == $past(low_counter_reg) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("low counter did not advance"); // (R7)

  property p_low_toggle;
    @(posedge pclk) disable iff (!presetn)
    (low_evt && !outctl_wr) |=> out_ff_reg != $past(out_ff_reg) && irq_stat_reg[`CT16_IRQ_LOW];
  endproperty
  a_low_toggle: assert property (p_low_toggle) else $error("low match lost"); // (R8)

  // Only judged while the setting holds for two cycles, so a stop or reprogram is no failure
  property p_fast_tap;
    @(posedge pclk) disable iff (!presetn)
    (run && timer_clock_select_a_reg == `CT16_CODE_INT_FIRST && oscillation_mode_reg) ##1
      (run && timer_clock_select_a_reg == `CT16_CODE_INT_FIRST && oscillation_mode_reg) |->
      tick != $past(tick);
  endproperty
  a_fast_tap: assert property (p_fast_tap) else $error("fastest tap not every two cycles"); // (R9)

  property p_level_set;
    @(posedge pclk) disable iff (!presetn)
    (outctl_wr && pwdata[`CT16_BIT_LVL_SET] && !pwdata[`CT16_BIT_LVL_RESET]) |=> out_ff_reg;
  endproperty
  a_level_set: assert property (p_level_set) else $error("output level not preset"); // (R10)

  property p_ext_rise;
    @(posedge pclk) disable iff (!presetn)
    (run && timer_clock_select_a_reg == 4'h1 && external_count_input && !$past(external_count_input)) |-> tick;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("rising edge not counted"); // (R11)

  property p_coherent;
    @(posedge pclk) disable iff (!presetn)
    (rd_setup && paddr == `CT16_OFF_COUNT) |=>
      prdata[15:0] == {$past(high_counter_reg), $past(low_counter_reg)};
  endproperty
  a_coherent: assert property (p_coherent) else $error("torn count read"); // (R12)

  c_full_match: cover property (@(posedge pclk) disable iff (!presetn) high_evt);
  c_low_only: cover property (@(posedge pclk) disable iff (!presetn) low_evt && !full_hit);
  c_overflow: cover property (@(posedge pclk) disable iff (!presetn) tick && low_counter_reg == 8'hff);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule // ct16_timer

// ===== rtl/ct16_map.svh
// Purpose: Register map, field positions and reset values of the cascaded timer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef CT16_MAP_SVH
`define CT16_MAP_SVH

`define CT16_ADDR_W 12
`define CT16_OFF_MODE 12'h000
`define CT16_OFF_CLKSEL 12'h004
`define CT16_OFF_OUTCTL 12'h008
`define CT16_OFF_LOW_CMP 12'h00c
`define CT16_OFF_HIGH_CMP 12'h010
`define CT16_OFF_COUNT 12'h014
`define CT16_OFF_OSC 12'h018
`define CT16_OFF_IRQ_STAT 12'h01c
`define CT16_OFF_IRQ_CLR 12'h020
`define CT16_OFF_IRQ_EN 12'h024

`define CT16_BIT_EN 0
`define CT16_BIT_CASCADE 2
`define CT16_BIT_LVL_RESET 2
`define CT16_BIT_LVL_SET 3
`define CT16_BIT_OSC 0
`define CT16_IRQ_LOW 0
`define CT16_IRQ_HIGH 1

`define CT16_RST_MODE 8'h00
`define CT16_RST_CLKSEL 4'h0
`define CT16_RST_CMP 8'h00
`define CT16_RST_OSC 1'b0
`define CT16_RST_IRQ 2'h0

`define CT16_PRESC_W 12
`define CT16_CODE_INT_FIRST 4'h6
`define CT16_CODE_INT_LAST 4'he
`define CT16_CODE_SLOWEST 4'hf
`define CT16_EXP_SLOWEST 4'hb
`define CT16_CODE_EXP_BIAS 4'h5

`endif

// ===== rtl/ct16_pkg.sv
// Purpose: Shared types of the cascaded timer
// Assumes: Nothing
// Notes: Constants live in ct16_map.svh
package ct16_pkg;
  typedef logic [7:0] ct16_byte_t;
  typedef enum logic [1:0] {
    CT16_SRC_EXT,
    CT16_SRC_INT,
    CT16_SRC_NONE
  } ct16_src_e;
endpackage

// ===== rtl/ct16_prescaler.sv
// Purpose: Free-running divider of pclk giving one tick every 2^exp cycles
// Assumes: exp between 1 and 12
// Notes: Taps are the AND of the low counter bits
`timescale 1ns/1ps
`include "ct16_map.svh"
module ct16_prescaler
  import ct16_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] exp_sel,
  output logic tick
);
  logic [`CT16_PRESC_W-1:0] div_reg;
  logic [`CT16_PRESC_W-1:0] taps;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign taps[0] = div_reg[0];
  genvar i;
  generate
    for (i = 1; i < `CT16_PRESC_W; i++) begin : g_tap
      assign taps[i] = taps[i-1] & div_reg[i];
    end
  endgenerate

  always_comb begin
    tick = 1'b0;
    if (exp_sel != 4'h0 && exp_sel <= 4'(`CT16_PRESC_W)) begin
      tick = taps[exp_sel - 4'h1];
    end
  end
endmodule // ct16_prescaler

// ===== rtl/ct16_edge_det.sv
// Purpose: Edge detector for the external count input
// Assumes: Input already synchronous to pclk
// Notes: rise_sel picks the rising edge, else the falling edge
`timescale 1ns/1ps
module ct16_edge_det
  import ct16_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  input wire logic rise_sel,
  output logic edge_tick
);
  logic prev_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_in;
    end
  end

  assign edge_tick = rise_sel ? (pin_in & ~prev_reg) : (~pin_in & prev_reg);
endmodule // ct16_edge_det

// ===== verif/ct16_pulse_src.sv
// Purpose: Pulse source on the external count input
// Assumes: Pin rests low between bursts
// Notes: Each pulse is low then high for hold+1 cycles each
`timescale 1ns/1ps
module ct16_pulse_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [15:0] n_pulses,
  input wire logic [3:0] hold,
  output logic pin,
  output logic busy
);
  logic [15:0] left;
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin <= 1'b0;
      busy <= 1'b0;
      left <= 16'h0000;
      cnt <= 4'h0;
    end else if (start && !busy) begin
      busy <= (n_pulses != 16'h0000);
      left <= n_pulses;
      cnt <= 4'h0;
    end else if (busy) begin
      if (cnt == hold) begin
        cnt <= 4'h0;
        pin <= ~pin;
        // Burst always ends low, so no stray edge follows
        if (pin) begin
          left <= left - 16'h0001;
          busy <= (left != 16'h0001);
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // ct16_pulse_src

// ===== verif/tb.sv
// Purpose: Self-checking bench of the cascaded timer
// Assumes: Zero-wait APB slave, pulse source on the count pin
// Notes: Interrupt periods are timed between two matches, as the first may come early
`timescale 1ns/1ps
`include "ct16_map.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic start = 1'b0;
  logic [15:0] n_pulses = 16'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, first_timer_output, irq, pin, busy, e;
  logic [15:0] tn[5] = '{16'h0100, 16'h0003, 16'h0002, 16'h0001, 16'h0000};
  logic [3:0] tc[5] = '{4'h6, 4'h6, 4'h7, 4'hf, 4'hf};
  logic to[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [31:0] modes[2] = '{32'h1, 32'h4};
  time t1, t2;
  int ex;
  int n_fail = 0;
  int n_tests = 0;
  ct16_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(pin), .first_timer_output(first_timer_output), .irq(irq));
  ct16_pulse_src i_src (.pclk(pclk), .presetn(presetn), .start(start), .n_pulses(n_pulses),
    .hold(4'h1), .pin(pin), .busy(busy));
  task automatic conclude();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      check(32'h0, 32'h1);
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic pulse(input logic [15:0] n);
    int k;
    k = 0;
    @(posedge pclk);
    n_pulses <= n;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    do begin
      @(posedge pclk);
      k++;
    end while (busy !== 1'b0 && k < 5000);
    if (busy !== 1'b0) begin
      check(32'h0, 32'h1);
      conclude();
    end
    // Margin for edge detection and count update
    repeat (4) @(posedge pclk);
  endtask
  task automatic wait_irq(output time t);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (irq !== 1'b1 && k < 10000);
    if (irq !== 1'b1) begin
      check(32'h0, 32'h1);
      conclude();
    end
    t = $time;
  endtask
  initial begin
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 40; a += 4) rd(12'(a), 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    check(32'(e), 32'h1);
    wr(`CT16_OFF_COUNT, 32'h1234);
    rd(`CT16_OFF_COUNT, 32'h0);
    wr(`CT16_OFF_LOW_CMP, 32'hffffffff);
    rd(`CT16_OFF_LOW_CMP, 32'hff);
    wr(`CT16_OFF_OUTCTL, 32'h8);
    @(negedge pclk);
    check(32'(first_timer_output), 32'h1);
    wr(`CT16_OFF_OUTCTL, 32'h4);
    @(negedge pclk);
    check(32'(first_timer_output), 32'h0);
    wr(`CT16_OFF_LOW_CMP, 32'h3);
    wr(`CT16_OFF_HIGH_CMP, 32'h2);
    wr(`CT16_OFF_CLKSEL, 32'h1);
    wr(`CT16_OFF_IRQ_EN, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wr(`CT16_OFF_MODE, modes[i]);
      pulse(16'h0003);
      rd(`CT16_OFF_COUNT, 32'h0);
    end
    wr(`CT16_OFF_MODE, 32'h5);
    pulse(16'h0100);
    rd(`CT16_OFF_COUNT, 32'h100);
    rd(`CT16_OFF_IRQ_STAT, 32'h1);
    check(32'(first_timer_output), 32'h1);
    check(32'(irq), 32'h1);
    wr(`CT16_OFF_IRQ_EN, 32'h0);
    @(negedge pclk);
    check(32'(irq), 32'h0);
    wr(`CT16_OFF_IRQ_CLR, 32'h1);
    rd(`CT16_OFF_IRQ_STAT, 32'h0);
    wr(`CT16_OFF_MODE, 32'h0);
    wr(`CT16_OFF_LOW_CMP, 32'h4);
    wr(`CT16_OFF_HIGH_CMP, 32'h0);
    wr(`CT16_OFF_CLKSEL, 32'h0);
    wr(`CT16_OFF_IRQ_EN, 32'h2);
    wr(`CT16_OFF_MODE, 32'h5);
    pulse(16'h0005);
    rd(`CT16_OFF_COUNT, 32'h0);
    rd(`CT16_OFF_IRQ_STAT, 32'h3);
    check(32'(irq), 32'h1);
    pulse(16'h0002);
    rd(`CT16_OFF_COUNT, 32'h2);
    wr(`CT16_OFF_MODE, 32'h0);
    wr(`CT16_OFF_CLKSEL, 32'h3);
    wr(`CT16_OFF_MODE, 32'h5);
    repeat (40) @(posedge pclk);
    rd(`CT16_OFF_COUNT, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`CT16_OFF_MODE, 32'h0);
      wr(`CT16_OFF_OSC, 32'(to[i]));
      wr(`CT16_OFF_CLKSEL, 32'(tc[i]));
      wr(`CT16_OFF_LOW_CMP, 32'(tn[i][7:0]));
      wr(`CT16_OFF_HIGH_CMP, 32'(tn[i][15:8]));
      wr(`CT16_OFF_IRQ_CLR, 32'h3);
      wr(`CT16_OFF_MODE, 32'h5);
      wait_irq(t1);
      wr(`CT16_OFF_IRQ_CLR, 32'h3);
      wait_irq(t2);
      ex = (tc[i] == 4'hf) ? 11 : int'(tc[i]) - 5;
      ex = ex + (to[i] ? 0 : 1);
      check(32'((t2 - t1) / 50), (32'(tn[i]) + 32'h1) << ex);
    end
    conclude();
  end
endmodule // tb
